// *** logic/parallel_port_pkg.sv ***
// Purpose: shared constants and carriers for the parallel port latch block
// Assumes: 8-bit ports, core clock domain only
// Notes: reset values are the latch contents after power-on
`default_nettype none
package parallel_port_pkg;
	localparam int PORT_W = 8;
	localparam logic [7:0] AD_LATCH_RST = 8'hFF;
	localparam logic [7:0] AN_LATCH_RST = 8'hFF;
	localparam logic [7:0] HI_LATCH_RST = 8'hFF;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam int TIMER2_COUNT_BIT = 0;
	localparam int TIMER2_CAPTURE_BIT = 1;
	localparam int SPI_SS_BIT = 5;
	localparam int PWM0_BIT = 6;
	localparam int PWM1_BIT = 7;

	// port selector used by the cpu strobes
	typedef enum logic [1:0] {
		PORT_AD = 2'h0,
		PORT_AN = 2'h1,
		PORT_HI = 2'h2,
		PORT_NONE = 2'h3
	} port_sel_t;

	// one cpu access to a port
	typedef struct packed {
		port_sel_t port;
		logic wr_latch;
		logic rd_latch;
		logic rd_pin;
		logic bit_op;
		logic [2:0] bit_idx;
		logic bit_val;
		logic [7:0] wdata;
	} cpu_req_t;

	// three signals of a pin group
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull;
	} pin_drive_t;
endpackage : parallel_port_pkg
`default_nettype wire

// *** logic/parallel_port_latch.sv ***
// Purpose: latches and read paths for three parallel ports, pin drivers for the address/data and high ports
// Assumes: cpu strobes and pins are synchronous to clk_sys_i
// Notes: pull outputs ask the pad ring for the weak pull-up
`timescale 1ns/100ps
`default_nettype none
module parallel_port_latch
	import parallel_port_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire cpu_req_t cpu_req_i,
	output logic [7:0] cpu_rdata_o,
	output logic cpu_rvalid_o,
	input wire logic ext_bus_sel_i,
	input wire logic [7:0] muxed_bus_i,
	input wire logic [7:0] location_bus_i,
	input wire logic [7:0] ad_pin_i,
	output pin_drive_t ad_drive_o,
	input wire logic [7:0] an_pin_i,
	output logic [7:0] an_analog_sel_o,
	output logic [7:0] an_digital_o,
	output logic timer2_count_input_o,
	output logic timer2_capture_trigger_o,
	output logic spi_slave_select_o,
	input wire logic [7:0] hi_pin_i,
	output pin_drive_t hi_drive_o,
	input wire logic pwm_sel_i,
	input wire logic [1:0] pwm_i,
	output logic [7:0] ad_latch_o,
	output logic [7:0] hi_latch_o
);

	// ****************************************
	// latches
	// ****************************************
	logic [7:0] ad_latch_ff;
	logic [7:0] an_latch_ff;
	logic [7:0] hi_latch_ff;
	logic [7:0] cur_latch;
	logic [7:0] nxt_wbyte;

	always_comb begin
		case (cpu_req_i.port)
			PORT_AD: cur_latch = ad_latch_ff;
			PORT_AN: cur_latch = an_latch_ff;
			PORT_HI: cur_latch = hi_latch_ff;
			default: cur_latch = 8'h00;
		endcase
	end

	// bit ops take the latch byte and change one bit
	always_comb begin
		nxt_wbyte = cpu_req_i.wdata;
		if (cpu_req_i.bit_op) begin
			nxt_wbyte = cur_latch;
			nxt_wbyte[cpu_req_i.bit_idx] = cpu_req_i.bit_val;
		end
	end

	// external access forces ones into the address/data latches
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ad_latch_ff <= AD_LATCH_RST;
		end else if (ext_bus_sel_i) begin
			ad_latch_ff <= ALL_ONES;
		end else if (cpu_req_i.wr_latch && cpu_req_i.port == PORT_AD) begin
			ad_latch_ff <= nxt_wbyte;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			an_latch_ff <= AN_LATCH_RST;
		end else if (cpu_req_i.wr_latch && cpu_req_i.port == PORT_AN) begin
			an_latch_ff <= nxt_wbyte;
		end
	end

	// high port latch is untouched by external accesses
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			hi_latch_ff <= HI_LATCH_RST;
		end else if (cpu_req_i.wr_latch && cpu_req_i.port == PORT_HI) begin
			hi_latch_ff <= nxt_wbyte;
		end
	end

	// ****************************************
	// cpu read paths
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cpu_rdata_o <= 8'h00;
			cpu_rvalid_o <= 1'b0;
		end else begin
			cpu_rvalid_o <= cpu_req_i.rd_latch | cpu_req_i.rd_pin;
			if (cpu_req_i.rd_latch) begin
				cpu_rdata_o <= cur_latch;
			end else if (cpu_req_i.rd_pin) begin
				case (cpu_req_i.port)
					PORT_AD: cpu_rdata_o <= ad_pin_i;
					PORT_AN: cpu_rdata_o <= an_pin_i;
					PORT_HI: cpu_rdata_o <= hi_pin_i;
					default: cpu_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ad_drive_o <= '0;
		end else if (ext_bus_sel_i) begin
			ad_drive_o.out <= muxed_bus_i;
			ad_drive_o.oe <= ALL_ONES;
			ad_drive_o.pull <= 8'h00;
		end else begin
			// open drain: only zeros drive
			ad_drive_o.out <= 8'h00;
			ad_drive_o.oe <= ~ad_latch_ff;
			ad_drive_o.pull <= 8'h00;
		end
	end

	logic [7:0] hi_gp;
	always_comb begin
		hi_gp = hi_latch_ff;
		if (pwm_sel_i) begin
			hi_gp[PWM0_BIT] = pwm_i[0];
			hi_gp[PWM1_BIT] = pwm_i[1];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			hi_drive_o.out <= 8'h00;
			hi_drive_o.oe <= 8'h00;
			hi_drive_o.pull <= ALL_ONES;
		end else if (ext_bus_sel_i) begin
			hi_drive_o.out <= location_bus_i;
			hi_drive_o.oe <= ALL_ONES;
			hi_drive_o.pull <= 8'h00;
		end else begin
			// ones pulled up, zeros driven low; with pwm_sel_i set, PWM0_BIT and PWM1_BIT are driven push-pull
			hi_drive_o.out <= 8'h00;
			hi_drive_o.oe <= ~hi_gp;
			hi_drive_o.pull <= hi_gp;
			if (pwm_sel_i) begin
				hi_drive_o.out[PWM0_BIT] <= pwm_i[0];
				hi_drive_o.out[PWM1_BIT] <= pwm_i[1];
				hi_drive_o.oe[PWM0_BIT] <= 1'b1;
				hi_drive_o.oe[PWM1_BIT] <= 1'b1;
				hi_drive_o.pull[PWM0_BIT] <= 1'b0;
				hi_drive_o.pull[PWM1_BIT] <= 1'b0;
			end
		end
	end

	// ****************************************
	// input-only port and alternate functions
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			an_analog_sel_o <= AN_LATCH_RST;
			an_digital_o <= 8'h00;
			timer2_count_input_o <= 1'b0;
			timer2_capture_trigger_o <= 1'b0;
			spi_slave_select_o <= 1'b1;
		end else begin
			an_analog_sel_o <= an_latch_ff;
			an_digital_o <= an_pin_i & ~an_latch_ff;
			timer2_count_input_o <= an_pin_i[TIMER2_COUNT_BIT];
			timer2_capture_trigger_o <= an_pin_i[TIMER2_CAPTURE_BIT];
			spi_slave_select_o <= an_pin_i[SPI_SS_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ad_latch_o <= AD_LATCH_RST;
			hi_latch_o <= HI_LATCH_RST;
		end else begin
			ad_latch_o <= ad_latch_ff;
			hi_latch_o <= hi_latch_ff;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_ext_sets_ad;
		@(posedge clk_sys_i) disable iff (rst_i) ext_bus_sel_i |=> ad_latch_ff == ALL_ONES;
	endproperty
	a_ext_sets_ad: assert property (p_ext_sets_ad) else $error("ad latch not set");

	property p_ad_push_pull;
		@(posedge clk_sys_i) disable iff (rst_i)
			ext_bus_sel_i |=> ad_drive_o.oe == ALL_ONES && ad_drive_o.out == $past(muxed_bus_i);
	endproperty
	a_ad_push_pull: assert property (p_ad_push_pull) else $error("ad not push-pull");

	property p_ad_open_drain;
		@(posedge clk_sys_i) disable iff (rst_i)
			!ext_bus_sel_i |=> ad_drive_o.oe == ~$past(ad_latch_ff) && ad_drive_o.out == 8'h00;
	endproperty
	a_ad_open_drain: assert property (p_ad_open_drain) else $error("ad gp drive wrong");

	property p_hi_kept;
		@(posedge clk_sys_i) disable iff (rst_i)
			ext_bus_sel_i && !cpu_req_i.wr_latch |=> $stable(hi_latch_ff);
	endproperty
	a_hi_kept: assert property (p_hi_kept) else $error("hi latch changed");

	property p_hi_addr;
		@(posedge clk_sys_i) disable iff (rst_i)
			ext_bus_sel_i |=> hi_drive_o.out == $past(location_bus_i) && hi_drive_o.oe == ALL_ONES;
	endproperty
	a_hi_addr: assert property (p_hi_addr) else $error("hi addr not driven");

	property p_rd_latch;
		@(posedge clk_sys_i) disable iff (rst_i)
			cpu_req_i.rd_latch && cpu_req_i.port == PORT_AN |=> cpu_rdata_o == $past(an_latch_ff);
	endproperty
	a_rd_latch: assert property (p_rd_latch) else $error("read latch wrong");

	property p_rd_pin;
		@(posedge clk_sys_i) disable iff (rst_i)
			cpu_req_i.rd_pin && !cpu_req_i.rd_latch && cpu_req_i.port == PORT_HI
			|=> cpu_rdata_o == $past(hi_pin_i) && cpu_rvalid_o;
	endproperty
	a_rd_pin: assert property (p_rd_pin) else $error("read pin wrong");

	property p_pwm;
		@(posedge clk_sys_i) disable iff (rst_i)
			pwm_sel_i && !ext_bus_sel_i |=> hi_drive_o.out[PWM1_BIT] == $past(pwm_i[1]);
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm not overriding");

	property p_bit_op;
		@(posedge clk_sys_i) disable iff (rst_i)
			cpu_req_i.wr_latch && cpu_req_i.bit_op && cpu_req_i.port == PORT_HI
			|=> hi_latch_ff[$past(cpu_req_i.bit_idx)] == $past(cpu_req_i.bit_val);
	endproperty
	a_bit_op: assert property (p_bit_op) else $error("bit op wrong");

	property p_ad_write;
		@(posedge clk_sys_i) disable iff (rst_i)
			cpu_req_i.wr_latch && !cpu_req_i.bit_op && cpu_req_i.port == PORT_AD
			&& !ext_bus_sel_i |=> ad_latch_ff == $past(cpu_req_i.wdata);
	endproperty
	a_ad_write: assert property (p_ad_write) else $error("ad write lost");

	property p_an_write;
		@(posedge clk_sys_i) disable iff (rst_i)
			cpu_req_i.wr_latch && !cpu_req_i.bit_op && cpu_req_i.port == PORT_AN
			|=> an_latch_ff == $past(cpu_req_i.wdata);
	endproperty
	a_an_write: assert property (p_an_write) else $error("an write lost");

	property p_rvalid;
		@(posedge clk_sys_i) disable iff (rst_i)
			1'b1 |=> cpu_rvalid_o == $past(cpu_req_i.rd_latch | cpu_req_i.rd_pin);
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read valid wrong");

	property p_ad_no_pull;
		@(posedge clk_sys_i) disable iff (rst_i)
			1'b1 |=> ad_drive_o.pull == 8'h00;
	endproperty
	a_ad_no_pull: assert property (p_ad_no_pull) else $error("ad pull requested");

	property p_hi_gp;
		@(posedge clk_sys_i) disable iff (rst_i)
			!ext_bus_sel_i && !pwm_sel_i |=> hi_drive_o.oe == ~$past(hi_latch_ff)
			&& hi_drive_o.pull == $past(hi_latch_ff) && hi_drive_o.out == 8'h00;
	endproperty
	a_hi_gp: assert property (p_hi_gp) else $error("hi gp drive wrong");

	property p_an_sel;
		@(posedge clk_sys_i) disable iff (rst_i)
			1'b1 |=> an_analog_sel_o == $past(an_latch_ff);
	endproperty
	a_an_sel: assert property (p_an_sel) else $error("analog select wrong");

	property p_alt_fn;
		@(posedge clk_sys_i) disable iff (rst_i)
			1'b1 |=> spi_slave_select_o == $past(an_pin_i[SPI_SS_BIT])
			&& timer2_count_input_o == $past(an_pin_i[TIMER2_COUNT_BIT]);
	endproperty
	a_alt_fn: assert property (p_alt_fn) else $error("alternate input wrong");

endmodule : parallel_port_latch
`default_nettype wire

// *** sim/port_far_side.sv ***
// Purpose: board side of the address/data and high port pin groups
// Assumes: board pull-ups on every address/data and high-port pin
// Notes: ext_low_i marks pins that another device pulls low
`timescale 1ns/100ps
`default_nettype none
module port_far_side
	import parallel_port_pkg::*;
(
	input wire pin_drive_t ad_drive_i,
	input wire pin_drive_t hi_drive_i,
	input wire logic [7:0] ext_low_i,
	output logic [7:0] ad_pin_o,
	output logic [7:0] hi_pin_o
);
	// released lines settle high unless another device pulls them down
	assign ad_pin_o = (ad_drive_i.oe & ad_drive_i.out) | (~ad_drive_i.oe & ~ext_low_i);
	assign hi_pin_o = (hi_drive_i.oe & hi_drive_i.out) | (~hi_drive_i.oe & ~ext_low_i);
endmodule : port_far_side
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for the parallel port latch block
// Assumes: inputs change 1 ns after the rising edge
// Notes: drives settle one cycle after the latch, so checks wait two edges
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import parallel_port_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	cpu_req_t req = '0;
	logic ext_sel = 1'b0;
	logic pwm_sel = 1'b0;
	logic [1:0] pwm = 2'h0;
	logic [7:0] mux_bus = 8'h00, loc_bus = 8'h00, an_pin = 8'hFF, ext_low = 8'h00;
	logic [7:0] ad_pin, hi_pin, rdata, an_sel, an_dig, ad_latch, hi_latch;
	logic rvalid, t2c, t2x, ss;
	pin_drive_t ad_drv, hi_drv;
	int bad_count = 0;
	int checks = 0;
	int cycles = 0;
	parallel_port_latch i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cpu_req_i(req),
		.cpu_rdata_o(rdata), .cpu_rvalid_o(rvalid), .ext_bus_sel_i(ext_sel),
		.muxed_bus_i(mux_bus), .location_bus_i(loc_bus), .ad_pin_i(ad_pin),
		.ad_drive_o(ad_drv), .an_pin_i(an_pin), .an_analog_sel_o(an_sel),
		.an_digital_o(an_dig), .timer2_count_input_o(t2c), .timer2_capture_trigger_o(t2x),
		.spi_slave_select_o(ss), .hi_pin_i(hi_pin), .hi_drive_o(hi_drv),
		.pwm_sel_i(pwm_sel), .pwm_i(pwm), .ad_latch_o(ad_latch), .hi_latch_o(hi_latch));
	port_far_side i_far (.ad_drive_i(ad_drv), .hi_drive_i(hi_drv), .ext_low_i(ext_low),
		.ad_pin_o(ad_pin), .hi_pin_o(hi_pin));
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// k = {write, read latch, read pin, bit op}
	task automatic cpu(input port_sel_t p, input logic [3:0] k, input logic [2:0] idx,
		input logic bv, input logic [7:0] wd);
		@(posedge clk_sys_i);
		#1;
		req = '{port: p, wr_latch: k[3], rd_latch: k[2], rd_pin: k[1], bit_op: k[0],
			bit_idx: idx, bit_val: bv, wdata: wd};
		@(posedge clk_sys_i);
		#1;
		req = '0;
	endtask : cpu
	task automatic rd(input port_sel_t p, input logic [3:0] k, input logic [7:0] exp);
		cpu(p, k, 3'h0, 1'b0, 8'h00);
		chk("rvalid", 8'h01, {7'h00, rvalid});
		chk("rdata", exp, rdata);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : idle
	task automatic t_ad;
		cpu(PORT_AD, 4'h8, 3'h0, 1'b0, 8'h5A);
		idle(2);
		chk("ad_oe", 8'hA5, ad_drv.oe);
		chk("ad_out", 8'h00, ad_drv.out & ad_drv.oe);
		chk("ad_pull", 8'h00, ad_drv.pull);
		rd(PORT_NONE, 4'h4, 8'h00);
		ext_low = 8'h02;
		rd(PORT_AD, 4'h4, 8'h5A);
		rd(PORT_AD, 4'h2, 8'h58);
		ext_low = 8'h00;
		$display("test ad done");
	endtask : t_ad
	task automatic t_ext;
		cpu(PORT_HI, 4'h8, 3'h0, 1'b0, 8'h33);
		mux_bus = 8'h3C;
		loc_bus = 8'hA5;
		ext_sel = 1'b1;
		cpu(PORT_AD, 4'h8, 3'h0, 1'b0, 8'h00);
		idle(2);
		chk("ad_oe", 8'hFF, ad_drv.oe);
		chk("ad_out", 8'h3C, ad_drv.out);
		chk("hi_oe", 8'hFF, hi_drv.oe);
		chk("hi_out", 8'hA5, hi_drv.out);
		chk("ad_latch", 8'hFF, ad_latch);
		chk("hi_latch", 8'h33, hi_latch);
		ext_sel = 1'b0;
		idle(2);
		chk("ad_oe", 8'h00, ad_drv.oe);
		chk("hi_oe", 8'hCC, hi_drv.oe);
		chk("hi_pull", 8'h33, hi_drv.pull);
		$display("test ext done");
	endtask : t_ext
	task automatic t_bit;
		cpu(PORT_HI, 4'h9, 3'h7, 1'b1, 8'h00);
		cpu(PORT_HI, 4'h9, 3'h0, 1'b0, 8'hFF);
		idle(1);
		chk("hi_latch", 8'hB2, hi_latch);
		ext_low = 8'h80;
		rd(PORT_HI, 4'h6, 8'hB2);
		rd(PORT_HI, 4'h2, 8'h32);
		ext_low = 8'h00;
		$display("test bit done");
	endtask : t_bit
	task automatic t_pwm;
		pwm_sel = 1'b1;
		pwm = 2'h1;
		idle(2);
		chk("pwm_out", 8'h01, {6'h00, hi_drv.out[7:6]});
		chk("pwm_oe", 8'h03, {6'h00, hi_drv.oe[7:6]});
		pwm = 2'h2;
		idle(2);
		chk("pwm_out", 8'h02, {6'h00, hi_drv.out[7:6]});
		pwm_sel = 1'b0;
		$display("test pwm done");
	endtask : t_pwm
	task automatic t_an;
		an_pin = 8'h21;
		cpu(PORT_AN, 4'h8, 3'h0, 1'b0, 8'hFE);
		idle(2);
		chk("an_sel", 8'hFE, an_sel);
		chk("an_dig", 8'h01, an_dig);
		chk("alt_fn", 8'h05, {5'h00, ss, t2x, t2c});
		rd(PORT_AN, 4'h2, 8'h21);
		$display("test an done");
	endtask : t_an
	task automatic t_rst;
		chk("ad_latch", 8'hFF, ad_latch);
		chk("an_sel", 8'hFF, an_sel);
		rd(PORT_AN, 4'h4, 8'hFF);
		$display("test reset done");
	endtask : t_rst
	initial begin
		idle(12);
		rst_i = 1'b0;
		idle(1);
		t_rst();
		t_ad();
		t_ext();
		t_bit();
		t_pwm();
		t_an();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
